// ---- rmwc_defs.svh ----
// constants for the retention mode wakeup controller
//
// Function
// - timers-on mode keeps low-frequency oscillator and timers
// - timers-on wakes on pin, tick, comparator
// - pin wakeup running within 100 us
// - tick wakeup prestarts regulators, ready at tick; code starts them at the tick, ready after prestart or stable crystal
// - short prestart when crystal not enabled
// - timers-on wakeup always resets the system
// - register retention keeps registers and all memory
// - register retention wakes only on pin without lf clock; with it on pin, tick, comparator
// - register retention startup timing matches timers-on
// - register retention wakeup resumes without reset
// - timers-off keeps manager, ram; pin wake resets
`ifndef RMWC_DEFS_SVH
`define RMWC_DEFS_SVH

// avalon register byte offsets
`define RMWC_OFS_MODE      4'h0
`define RMWC_OFS_CTRL      4'h4
`define RMWC_OFS_STATUS    4'h8

// power-down mode codes written to the mode register
`define RMWC_CODE_ACTIVE   3'h0
`define RMWC_CODE_MEM_RET  3'h3
`define RMWC_CODE_REG_RET  3'h4

// control register fields
`define RMWC_CTRL_XOSC_EN_LO   4
`define RMWC_CTRL_XOSC_EN_HI   5
`define RMWC_CTRL_XOSC_RET     7
`define RMWC_CTRL_RESET        8'h00

// timing
`define RMWC_CLK_MHZ        100
`define RMWC_PIN_START_NS   100000
`define RMWC_PIN_START_CYC  ((`RMWC_PIN_START_NS * `RMWC_CLK_MHZ) / 1000)
`define RMWC_SHORT_PRE_CYC  4

`endif

// ---- rmwc_pkg.sv ----
// types for the retention mode wakeup controller
package rmwc_pkg;
    // which power domains and oscillators stay on
    typedef struct packed {
        logic core_on;       // registers and main data memory
        logic ram_on;        // scratch ram and retentive memory
        logic lf_osc_on;     // low-frequency oscillator
        logic timers_on;     // sleep tick timer and watchdog clock
        logic hf_xosc_on;    // high-frequency crystal
        logic regulators_on; // main voltage regulators
        logic mcu_clk_on;    // mcu clock released
    } rmwc_power_s;

    typedef enum logic [2:0] {
        RMWC_ACTIVE  = 3'b000,
        RMWC_MEMOFF  = 3'b001,
        RMWC_MEMON   = 3'b010,
        RMWC_REGOFF  = 3'b011,
        RMWC_REGON   = 3'b100,
        RMWC_WAKE    = 3'b101
    } rmwc_state_e;
endpackage : rmwc_pkg

// ---- rmwc_sync3.sv ----
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module rmwc_sync3 #(
    parameter int WIDTH = 3
) (
    // clock and reset
    input  wire logic             i_sys_clk,
    input  wire logic             i_srst,
    // asynchronous inputs and filtered result
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_level
);
    logic [WIDTH-1:0] s1_q;  // metastable stage, read only by s2
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;

    // shift chain
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= i_async;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // change counts only once stages two and three agree
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            always_ff @(posedge i_sys_clk) begin
                if (i_srst) begin
                    o_level[g] <= 1'b0;
                end else if (s2_q[g] == s3_q[g]) begin
                    o_level[g] <= s3_q[g];
                end
            end
        end
    endgenerate
endmodule : rmwc_sync3

// ---- rmwc_ctrl.sv ----
// retention mode wakeup controller with avalon register slave
`timescale 1ns/1ps
`include "rmwc_defs.svh"
module rmwc_ctrl #(
    parameter int PIN_START_CYC = `RMWC_PIN_START_CYC
) (
    // clock and reset
    input  wire logic                 i_sys_clk,
    input  wire logic                 i_srst,
    // avalon-mm slave
    input  wire logic [3:0]           i_avs_address,
    input  wire logic                 i_avs_read,
    input  wire logic                 i_avs_write,
    input  wire logic [31:0]          i_avs_writedata,
    output logic      [31:0]          o_avs_readdata,
    output logic                      o_avs_waitrequest,
    // wakeup sources from pins, comparator and sleep tick
    input  wire logic                 i_wake_pin,
    input  wire logic                 i_wake_comp,
    input  wire logic                 i_tick,
    // oscillator status and selection
    input  wire logic                 i_hf_xosc_stable,
    input  wire logic                 i_lf_clk_active,
    // power control outputs
    output rmwc_pkg::rmwc_power_s     o_power,
    output logic                      o_sys_reset,
    output logic                      o_resume
);
    import rmwc_pkg::*;

    logic [3:0]   wake_s;        // filtered pin, comparator, tick, crystal stable
    logic         xosc_stable_s; // crystal stable after the input filter
    logic         pin_w;
    logic         comp_w;
    logic         tick_w;
    logic [2:0]   wake_prev_q;   // for rising edge detection
    logic         pin_rise;
    logic         comp_rise;
    logic         tick_rise;
    rmwc_state_e  state_q;
    rmwc_state_e  from_q;        // mode woken from
    logic         by_tick_q;     // wakeup caused by tick
    logic [7:0]   ctrl_q;        // mcu clock control bits
    logic [2:0]   mode_q;        // last mode code written, set back to active on wakeup
    logic [31:0]  cnt_q;         // startup counter
    logic         xosc_en;
    logic         ack_q;

    // filter asynchronous sources; tick also comes off the slow clock
    // crystal status comes from the oscillator, so it is filtered as well
    rmwc_sync3 #(.WIDTH(4)) u_sync (
        .i_sys_clk (i_sys_clk),
        .i_srst    (i_srst),
        .i_async   ({i_hf_xosc_stable, i_tick, i_wake_comp, i_wake_pin}),
        .o_level   (wake_s)
    );
    assign pin_w         = wake_s[0];
    assign comp_w        = wake_s[1];
    assign tick_w        = wake_s[2];
    assign xosc_stable_s = wake_s[3];

    // edge detect so a held level wakes once
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            wake_prev_q <= 3'h0;
        end else begin
            wake_prev_q <= wake_s[2:0];
        end
    end
    assign pin_rise  = pin_w & ~wake_prev_q[0];
    assign comp_rise = comp_w & ~wake_prev_q[1];
    assign tick_rise = tick_w & ~wake_prev_q[2];

    // crystal enabled when either enable bit is set
    assign xosc_en = ctrl_q[`RMWC_CTRL_XOSC_EN_HI] | ctrl_q[`RMWC_CTRL_XOSC_EN_LO];

    // avalon handshake: one wait cycle then answer
    // waitrequest has its own flop so the pin never sees a gate
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            ack_q             <= 1'b0;
            o_avs_waitrequest <= 1'b1;
        end else begin
            ack_q             <= (i_avs_read | i_avs_write) & ~ack_q;
            o_avs_waitrequest <= ~((i_avs_read | i_avs_write) & ~ack_q);
        end
    end

    // control register write
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            ctrl_q <= `RMWC_CTRL_RESET;
        end else if (ack_q && i_avs_write && i_avs_address == `RMWC_OFS_CTRL) begin
            ctrl_q <= i_avs_writedata[7:0];
        end
    end

    // read mux; unmapped reads give zero
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_avs_readdata <= 32'h0;
        end else if (i_avs_read && !ack_q) begin
            unique case (i_avs_address)
                `RMWC_OFS_MODE:   o_avs_readdata <= {29'h0, mode_q};
                `RMWC_OFS_CTRL:   o_avs_readdata <= {24'h0, ctrl_q};
                `RMWC_OFS_STATUS: o_avs_readdata <= {26'h0, by_tick_q, state_q,
                                                     xosc_stable_s, i_lf_clk_active};
                default:          o_avs_readdata <= 32'h0;
            endcase
        end
    end

    // mode sequencer
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            state_q   <= RMWC_ACTIVE;
            from_q    <= RMWC_ACTIVE;
            by_tick_q <= 1'b0;
            mode_q    <= `RMWC_CODE_ACTIVE;
            cnt_q     <= 32'h0;
        end else begin
            unique case (state_q)
                RMWC_ACTIVE: begin
                    // a retention mode code (memory or register) written as data enters power-down; other codes only update mode_q
                    if (ack_q && i_avs_write && i_avs_address == `RMWC_OFS_MODE) begin
                        mode_q <= i_avs_writedata[2:0];
                        if (i_avs_writedata[2:0] == `RMWC_CODE_REG_RET) begin
                            // timers on follows the low-frequency source
                            state_q <= i_lf_clk_active ? RMWC_REGON : RMWC_REGOFF;
                        end else if (i_avs_writedata[2:0] == `RMWC_CODE_MEM_RET) begin
                            state_q <= i_lf_clk_active ? RMWC_MEMON : RMWC_MEMOFF;
                        end
                    end
                end
                RMWC_MEMOFF, RMWC_REGOFF: begin
                    // only pin wakes; others ignored
                    if (pin_rise) begin
                        from_q    <= state_q;
                        by_tick_q <= 1'b0;
                        cnt_q     <= 32'h0;
                        state_q   <= RMWC_WAKE;
                    end
                end
                RMWC_MEMON, RMWC_REGON: begin
                    // pin, comparator or tick wake
                    if (pin_rise || comp_rise || tick_rise) begin
                        from_q    <= state_q;
                        by_tick_q <= tick_rise & ~pin_rise & ~comp_rise;
                        cnt_q     <= 32'h0;
                        state_q   <= RMWC_WAKE;
                    end
                end
                RMWC_WAKE: begin
                    // same startup timing from either retention mode
                    cnt_q <= cnt_q + 32'h1;
                    if (by_tick_q) begin
                        // prestart, ready once short prestart or stable crystal
                        if (!xosc_en ? (cnt_q >= 32'(`RMWC_SHORT_PRE_CYC - 1))
                                     : xosc_stable_s) begin
                            state_q <= RMWC_ACTIVE;
                            mode_q  <= `RMWC_CODE_ACTIVE;
                        end
                    end else if ((xosc_en ? xosc_stable_s : 1'b1) &&
                                 cnt_q >= 32'(PIN_START_CYC / 2)) begin
                        state_q <= RMWC_ACTIVE;
                        mode_q  <= `RMWC_CODE_ACTIVE;
                    end
                end
                default: state_q <= RMWC_ACTIVE;
            endcase
        end
    end

    // reset on wake from memory retention, resume from register retention
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_sys_reset <= 1'b0;
            o_resume    <= 1'b0;
        end else begin
            o_sys_reset <= (state_q == RMWC_WAKE) && (from_q == RMWC_MEMON ||
                                                      from_q == RMWC_MEMOFF);
            o_resume    <= (state_q == RMWC_WAKE) && (from_q == RMWC_REGON ||
                                                      from_q == RMWC_REGOFF);
        end
    end

    // domain and oscillator enables per mode
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_power <= '{default: 1'b1};
        end else begin
            unique case (state_q)
                RMWC_MEMOFF: o_power <= '{core_on: 1'b0, ram_on: 1'b1, lf_osc_on: 1'b0,
                                          timers_on: 1'b0, hf_xosc_on: 1'b0,
                                          regulators_on: 1'b0, mcu_clk_on: 1'b0};
                RMWC_MEMON:  o_power <= '{core_on: 1'b0, ram_on: 1'b1, lf_osc_on: 1'b1,
                                          timers_on: 1'b1, hf_xosc_on: 1'b0,
                                          regulators_on: 1'b0, mcu_clk_on: 1'b0};
                RMWC_REGOFF, RMWC_REGON:
                             o_power <= '{core_on: 1'b1, ram_on: 1'b1,
                                          lf_osc_on: 1'b1, timers_on: 1'b1,
                                          hf_xosc_on: ctrl_q[`RMWC_CTRL_XOSC_RET],
                                          regulators_on: 1'b0, mcu_clk_on: 1'b0};
                RMWC_WAKE:   o_power <= '{core_on: 1'b1, ram_on: 1'b1, lf_osc_on: 1'b1,
                                          timers_on: 1'b1, hf_xosc_on: xosc_en,
                                          regulators_on: 1'b1, mcu_clk_on: 1'b0};
                RMWC_ACTIVE: o_power <= '{default: 1'b1};
            endcase
        end
    end
    // software idling in standby for the tick is outside this block
endmodule : rmwc_ctrl

// ---- rmwc_wake_src.sv ----
// wakeup pin and level comparator model facing the wakeup controller
`timescale 1ns/1ps
module rmwc_wake_src (
    // clock and triggers from the bench
    input  wire logic i_sys_clk,
    input  wire logic i_fire_pin,
    input  wire logic i_fire_comp,
    // wake lines toward the controller
    output logic      o_wake_pin,
    output logic      o_wake_comp
);
    logic [4:0] cnt_q       = 5'h00; // cycles the level is still held
    logic       pin_q       = 1'b0;  // pin event level
    logic       comp_q      = 1'b0;  // comparator output level
    assign o_wake_pin  = pin_q;
    assign o_wake_comp = comp_q;
    // a level held long enough that the input filter agrees on it
    always_ff @(posedge i_sys_clk) begin
        if (i_fire_pin || i_fire_comp) begin
            cnt_q  <= 5'h14;
            pin_q  <= i_fire_pin;
            comp_q <= i_fire_comp;
        end else if (cnt_q != 5'h00) begin
            cnt_q <= cnt_q - 5'h01;
        end else begin
            pin_q  <= 1'b0; // released lines fall to idle low
            comp_q <= 1'b0;
        end
    end
endmodule : rmwc_wake_src

// ---- rmwc_ctrl_sva.sv ----
// port assertions for the wakeup controller
`timescale 1ns/1ps
module rmwc_ctrl_sva import rmwc_pkg::*; #(
    parameter int PIN_START_CYC = 20
) (
    // clock and reset
    input wire logic        i_sys_clk,
    input wire logic        i_srst,
    // bus
    input wire logic [3:0]  i_avs_address,
    input wire logic        i_avs_read,
    input wire logic        i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [31:0] o_avs_readdata,
    input wire logic        o_avs_waitrequest,
    // wake and status
    input wire logic        i_wake_pin,
    input wire logic        i_wake_comp,
    input wire logic        i_tick,
    input wire logic        i_hf_xosc_stable,
    input wire logic        i_lf_clk_active,
    input rmwc_power_s      o_power,
    input wire logic        o_sys_reset,
    input wire logic        o_resume
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_srst);
    logic [5:0] since_q; // cycles since a wake line was last high
    // a wakeup must trace back to a recent source, so count since one
    always_ff @(posedge i_sys_clk) begin
        if (i_srst || i_wake_pin || i_wake_comp || i_tick) begin
            since_q <= 6'h00;
        end else if (since_q != 6'h3F) begin
            since_q <= since_q + 6'h01; // saturates, never wraps
        end
    end
    property p_wait_one; (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest; endproperty
    a_wait_one: assert property (p_wait_one) else $error("waitrequest not dropped");
    property p_ack_one; !o_avs_waitrequest |=> o_avs_waitrequest; endproperty
    a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
    property p_rd_hold; !i_avs_read && !$past(i_avs_read) |-> $stable(o_avs_readdata); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved without read");
    property p_ram_kept; o_power.ram_on; endproperty
    a_ram_kept: assert property (p_ram_kept) else $error("scratch ram lost power");
    property p_timers_lf; o_power.timers_on |-> o_power.lf_osc_on; endproperty
    a_timers_lf: assert property (p_timers_lf) else $error("timers without lf clock");
    property p_clk_stable; $rose(o_power.mcu_clk_on) && o_power.hf_xosc_on |-> i_hf_xosc_stable; endproperty
    a_clk_stable: assert property (p_clk_stable) else $error("clock before crystal");
    property p_resume_no_rst; o_resume |-> !o_sys_reset; endproperty
    a_resume_no_rst: assert property (p_resume_no_rst) else $error("reset on resume");
    property p_wake_cause; $rose(o_sys_reset) || $rose(o_resume) |-> since_q < PIN_START_CYC + 20; endproperty
    a_wake_cause: assert property (p_wake_cause) else $error("wake without source");
endmodule : rmwc_ctrl_sva
bind rmwc_ctrl rmwc_ctrl_sva #(.PIN_START_CYC(PIN_START_CYC)) u_sva (
    .i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
    .i_wake_pin(i_wake_pin), .i_wake_comp(i_wake_comp), .i_tick(i_tick),
    .i_hf_xosc_stable(i_hf_xosc_stable), .i_lf_clk_active(i_lf_clk_active),
    .o_power(o_power), .o_sys_reset(o_sys_reset), .o_resume(o_resume));

// ---- rmwc_ctrl_tb_top.sv ----
// self-checking bench for the retention mode wakeup controller
`timescale 1ns/1ps
`include "rmwc_defs.svh"
module rmwc_ctrl_tb_top;
    import rmwc_pkg::*;
    localparam int PSC = 20;            // shortened pin start count
    logic        clk = 1'b0, srst = 1'b1; // clock and reset
    logic [3:0]  addr = 4'h0;           // bus address
    logic        rd = 1'b0, wr = 1'b0;  // bus strobes
    logic [31:0] wdata = 32'h0, rdata, q;
    logic        wreq, pin, comp, sys_rst, resume;
    logic        fpin = 1'b0, fcomp = 1'b0, tick = 1'b0, xstab = 1'b1, lfact = 1'b0;
    rmwc_power_s pwr;                   // power outputs
    int          mismatches = 0, n_checks = 0;
    initial forever #5 clk = ~clk;
    rmwc_ctrl #(.PIN_START_CYC(PSC)) u_dut (.i_sys_clk(clk), .i_srst(srst),
        .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
        .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_wake_pin(pin),
        .i_wake_comp(comp), .i_tick(tick), .i_hf_xosc_stable(xstab),
        .i_lf_clk_active(lfact), .o_power(pwr), .o_sys_reset(sys_rst), .o_resume(resume));
    rmwc_wake_src u_src (.i_sys_clk(clk), .i_fire_pin(fpin), .i_fire_comp(fcomp),
        .o_wake_pin(pin), .o_wake_comp(comp));
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : tally_and_finish
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : check
    // one bus cycle, held until waitrequest is seen low at a rising edge
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 50);
        if (wreq !== 1'b0) begin
            mismatches++;
            tally_and_finish();
        end
        q = rdata; // value standing at the taking edge
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk); // idle edge so the next call never re-raises in this step
    endtask : bus
    task automatic fire(input logic [1:0] src);
        if (src == 2'd0) fpin <= 1'b1;
        else if (src == 2'd1) fcomp <= 1'b1;
        else tick <= 1'b1;
        @(posedge clk);
        fpin <= 1'b0;
        fcomp <= 1'b0;
    endtask : fire
    // enter a mode, check its power, wake it and see how it came back
    task automatic run(input logic [2:0] code, input logic lf, input logic [7:0] ctl,
                       input logic [1:0] s, input rmwc_state_e st);
        logic [1:0] rs, src;
        logic       rg, on;
        int         n;
        src = s;
        rg = (st == RMWC_REGOFF) || (st == RMWC_REGON);
        on = (st == RMWC_MEMON) || (st == RMWC_REGON);
        lfact <= lf;
        bus(1'b1, `RMWC_OFS_CTRL, {24'h0, ctl});
        bus(1'b0, `RMWC_OFS_CTRL, 32'h0);
        check(q, {24'h0, ctl});
        bus(1'b1, `RMWC_OFS_MODE, {29'h0, code});
        bus(1'b0, `RMWC_OFS_STATUS, 32'h0);
        check(q[4:2], st);
        bus(1'b0, `RMWC_OFS_MODE, 32'h0);
        check(q, {29'h0, code});
        check(pwr.core_on, rg);
        check({pwr.lf_osc_on, pwr.timers_on}, {on | rg, on | rg});
        if (rg) check(pwr.hf_xosc_on, ctl[7]);
        if (src != 2'd0 && !on) begin
            fire(src);
            repeat (40) @(posedge clk);
            check({sys_rst, resume}, 2'b00);
            src = 2'd0;
        end
        if (ctl[4]) xstab <= 1'b0;
        fire(src);
        if (ctl[4]) begin
            repeat (30) @(posedge clk);
            check({pwr.regulators_on, pwr.hf_xosc_on, pwr.mcu_clk_on, resume}, {2'h3, 1'b0, rg});
            xstab <= 1'b1;
        end
        n = 0;
        while (!(sys_rst || resume) && n < 300) begin
            @(negedge clk);
            n++;
        end
        rs = {sys_rst, resume};
        while ((sys_rst || resume) && n < 900) begin
            @(negedge clk);
            n++;
        end
        if (n >= 300) begin
            mismatches++;
            tally_and_finish();
        end
        @(posedge clk);
        tick <= 1'b0;
        check(rs, {!rg, rg});
        if (src == 2'd0) check(n < PSC, 1'b1);
        if (src == 2'd2 && !ctl[4]) check(n < 16, 1'b1);
        bus(1'b0, `RMWC_OFS_STATUS, 32'h0);
        check(q, {26'h0, src == 2'd2, RMWC_ACTIVE, 1'b1, lf});
        bus(1'b0, `RMWC_OFS_MODE, 32'h0);
        check(q, {29'h0, `RMWC_CODE_ACTIVE});
        check(pwr, 7'h7F);
    endtask : run
    initial begin
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        bus(1'b0, 4'hC, 32'h0);
        check(q, 32'h0);
        bus(1'b1, `RMWC_OFS_MODE, 32'h5);
        bus(1'b0, `RMWC_OFS_STATUS, 32'h0);
        check(q[4:2], RMWC_ACTIVE);
        run(`RMWC_CODE_MEM_RET, 1'b1, 8'h00, 2'd2, RMWC_MEMON);
        run(`RMWC_CODE_MEM_RET, 1'b1, 8'h00, 2'd1, RMWC_MEMON);
        run(`RMWC_CODE_MEM_RET, 1'b1, 8'h00, 2'd0, RMWC_MEMON);
        run(`RMWC_CODE_MEM_RET, 1'b0, 8'h00, 2'd2, RMWC_MEMOFF);
        run(`RMWC_CODE_REG_RET, 1'b0, 8'h00, 2'd1, RMWC_REGOFF);
        run(`RMWC_CODE_REG_RET, 1'b1, 8'h30, 2'd2, RMWC_REGON);
        run(`RMWC_CODE_REG_RET, 1'b0, 8'h80, 2'd0, RMWC_REGOFF);
        tally_and_finish();
    end
endmodule : rmwc_ctrl_tb_top
